// ==== verilog/bfc_map.vh ====
// Register offsets, field positions, reset values and decode constants.
`ifndef BFC_MAP_VH
`define BFC_MAP_VH
`define BFC_OFF_CTRL 8'h3e
`define BFC_OFF_CAPID 8'h50
`define BFC_OFF_NEXT 8'h51
`define BFC_OFF_CMD 8'h04
`define BFC_OFF_STAT 8'h70
`define BFC_OFF_MASK 8'h74
`define BFC_CAPID_VAL 8'h01
`define BFC_NEXT_VAL 8'h60
`define BFC_CTRL_RST 6'h00
`define BFC_CMD_RST 3'h0
`define BFC_B_PAR 0
`define BFC_B_SERR 1
`define BFC_B_ISA 2
`define BFC_B_VGA 3
`define BFC_B_LEGACY_VIDEO_FULL_DECODE 4
`define BFC_B_MAM 5
`define BFC_CMD_IO 0
`define BFC_CMD_MEM 1
`define BFC_CMD_SERR 2
`define BFC_VGA_MEM_LO 32'h000a0000
`define BFC_VGA_MEM_HI 32'h000bffff
`define BFC_VGA_IO_A_LO 10'h3b0
`define BFC_VGA_IO_A_HI 10'h3bb
`define BFC_VGA_IO_B_LO 10'h3c0
`define BFC_VGA_IO_B_HI 10'h3df
`define BFC_ISA_ALIAS_MIN 10'h100
`define BFC_ALL_ONES 32'hffffffff
`define BFC_EV_SERR 0
`define BFC_EV_PERR 1
`define BFC_EV_PWMA 2
`define BFC_EV_W 3
`endif

// ==== verilog/bfc_decode.v ====
// Address decode for downstream and upstream forwarding of one access.
`include "bfc_map.vh"
module bfc_decode (
	input wire [31:0] addr_i,
	input wire is_io_i,
	input wire is_mem_i,
	input wire in_window_i,
	input wire vga_en_i,
	input wire legacy_video_full_decode_i,
	input wire isa_en_i,
	input wire io_en_i,
	input wire mem_en_i,
	output wire down_o,
	output wire up_o
);
	function vga_io_hit;
		input [31:0] a;
		input full;
		begin
			vga_io_hit = (a[31:16] == 16'h0000) &&
				(!full || a[15:10] == 6'h00) &&
				((a[9:0] >= `BFC_VGA_IO_A_LO && a[9:0] <= `BFC_VGA_IO_A_HI) ||
				(a[9:0] >= `BFC_VGA_IO_B_LO && a[9:0] <= `BFC_VGA_IO_B_HI));
		end
	endfunction
	wire vga_mem = is_mem_i && addr_i >= `BFC_VGA_MEM_LO &&
		addr_i <= `BFC_VGA_MEM_HI;
	wire vga_io = is_io_i && vga_io_hit(addr_i, legacy_video_full_decode_i);
	wire vga_hit = vga_en_i && (vga_mem || vga_io);
	// Aliased ISA range: top 768 bytes of every 1 KB block in first 64 KB.
	wire isa_alias = is_io_i && addr_i[31:16] == 16'h0000 &&
		addr_i[9:0] >= `BFC_ISA_ALIAS_MIN;
	wire isa_block = isa_en_i && isa_alias && in_window_i;
	wire type_ok = (is_io_i && io_en_i) || (is_mem_i && mem_en_i);
	assign down_o = type_ok &&
		(vga_hit || (in_window_i && !isa_block));
	// Secondary-side access that is not a VGA hit is forwarded up when outside the window,
	// or when it is an ISA alias inside the window with ISA set.
	assign up_o = !vga_hit &&
		(!in_window_i || isa_block);
endmodule // bfc_decode

// ==== verilog/bfc_abort.v ====
// Master-abort and unsupported-request response selection.
`include "bfc_map.vh"
module bfc_abort (
	input wire mam_i,
	input wire pci_mabort_i,
	input wire pci_is_read_i,
	input wire pci_posted_i,
	input wire [31:0] pci_rdata_i,
	input wire pcie_ur_i,
	output wire [31:0] rdata_o,
	output wire drop_wr_o,
	output wire send_ur_o,
	output wire tabort_o,
	output wire pw_err_o
);
	assign rdata_o = (pci_mabort_i && !mam_i && pci_is_read_i) ?
		`BFC_ALL_ONES : pci_rdata_i;
	assign drop_wr_o = pci_mabort_i && !pci_is_read_i && !mam_i;
	assign send_ur_o = pci_mabort_i && mam_i && !pci_posted_i;
	assign tabort_o = pcie_ur_i && mam_i;
	assign pw_err_o = pci_mabort_i && pci_posted_i && mam_i;
endmodule // bfc_abort

// ==== verilog/bfc_top.v ====
// Bridge forwarding control bits, decode and error routing.
//
// Strobed register access was left to the implementer.
`include "bfc_map.vh"
// Overview of operation
// - ABORT_RESPONSE_MODE clear: all-ones reads, dropped writes
// - ABORT_RESPONSE_MODE set: non-posted PCI master abort gives UR
// - ABORT_RESPONSE_MODE set: PCIe UR gives target abort
// - ABORT_RESPONSE_MODE set: posted-write master abort signals error
// - Full decode checks I/O bits 15:10
// - VGA memory window forwarded downstream
// - VGA I/O ranges forwarded downstream
// - VGA accesses never forwarded upstream
// - VGA ignores ISA/windows, needs space enables
// - ISA set blocks downstream alias I/O
// - ISA set forwards alias I/O upstream
// - Secondary SERR forwarded only when both enabled
// - Parity response bit gates secondary error reports
// - PCI data errors always forwarded poisoned
// - Pm_capability_identifier reads fixed PM code
// - Next pointer reads MSI capability offset
module bfc_top (
	input wire clk_i,
	input wire arst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	output wire irq_o,
	input wire dec_valid_i,
	input wire dec_from_sec_i,
	input wire [31:0] dec_addr_i,
	input wire dec_is_io_i,
	input wire dec_is_mem_i,
	input wire dec_in_window_i,
	output reg dec_done_o,
	output reg dec_forward_o,
	input wire ab_mabort_i,
	input wire ab_is_read_i,
	input wire ab_posted_i,
	input wire [31:0] ab_rdata_i,
	input wire ab_pcie_ur_i,
	output reg [31:0] ab_rdata_o,
	output reg ab_drop_wr_o,
	output reg ab_send_ur_o,
	output reg ab_tabort_o,
	input wire sec_serr_n_i,
	input wire sec_perr_i,
	input wire pci_data_err_i,
	output reg pri_serr_o,
	output reg sec_perr_report_o,
	output reg poison_o
);
	reg [5:0] ctrl_q;
	reg [2:0] cmd_q;
	reg [`BFC_EV_W-1:0] stat_q;
	reg [`BFC_EV_W-1:0] mask_q;
	reg [2:0] serr_sync_q;
	reg serr_q;
	wire dec_down;
	wire dec_up;
	wire [31:0] ab_rdata;
	wire ab_drop;
	wire ab_ur;
	wire ab_ta;
	wire ab_pw_err;
	wire serr_fwd;
	wire perr_rep;
	wire [`BFC_EV_W-1:0] ev;

	// Control bits change only on a register write; every access is decoded
	// in one cycle against the bits that stand at its own edge.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= `BFC_CTRL_RST;
			cmd_q <= `BFC_CMD_RST;
			mask_q <= {`BFC_EV_W{1'b0}};
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`BFC_OFF_CTRL: begin
					ctrl_q <= reg_wdata_i[5:0];
				end
				`BFC_OFF_CMD: begin
					cmd_q[`BFC_CMD_IO] <= reg_wdata_i[0];
					cmd_q[`BFC_CMD_MEM] <= reg_wdata_i[1];
					cmd_q[`BFC_CMD_SERR] <= reg_wdata_i[8];
				end
				`BFC_OFF_MASK: begin
					mask_q <= reg_wdata_i[`BFC_EV_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	bfc_decode u_decode (
		.addr_i(dec_addr_i),
		.is_io_i(dec_is_io_i),
		.is_mem_i(dec_is_mem_i),
		.in_window_i(dec_in_window_i),
		.vga_en_i(ctrl_q[`BFC_B_VGA]),
		.legacy_video_full_decode_i(ctrl_q[`BFC_B_LEGACY_VIDEO_FULL_DECODE]),
		.isa_en_i(ctrl_q[`BFC_B_ISA]),
		.io_en_i(cmd_q[`BFC_CMD_IO]),
		.mem_en_i(cmd_q[`BFC_CMD_MEM]),
		.down_o(dec_down),
		.up_o(dec_up)
	);

	bfc_abort u_abort (
		.mam_i(ctrl_q[`BFC_B_MAM]),
		.pci_mabort_i(ab_mabort_i),
		.pci_is_read_i(ab_is_read_i),
		.pci_posted_i(ab_posted_i),
		.pci_rdata_i(ab_rdata_i),
		.pcie_ur_i(ab_pcie_ur_i),
		.rdata_o(ab_rdata),
		.drop_wr_o(ab_drop),
		.send_ur_o(ab_ur),
		.tabort_o(ab_ta),
		.pw_err_o(ab_pw_err)
	);

	// The secondary SERR pin is asynchronous; act once stages two and three
	// agree.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serr_sync_q <= 3'h0;
			serr_q <= 1'b0;
		end else begin
			serr_sync_q <= {serr_sync_q[1:0], !sec_serr_n_i};
			if (serr_sync_q[1] == serr_sync_q[2]) begin
				serr_q <= serr_sync_q[2];
			end
		end
	end

	assign serr_fwd = serr_q && ctrl_q[`BFC_B_SERR] &&
		cmd_q[`BFC_CMD_SERR];
	assign perr_rep = sec_perr_i && ctrl_q[`BFC_B_PAR];

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dec_done_o <= 1'b0;
			dec_forward_o <= 1'b0;
			ab_rdata_o <= 32'h00000000;
			ab_drop_wr_o <= 1'b0;
			ab_send_ur_o <= 1'b0;
			ab_tabort_o <= 1'b0;
			pri_serr_o <= 1'b0;
			sec_perr_report_o <= 1'b0;
			poison_o <= 1'b0;
		end else begin
			dec_done_o <= dec_valid_i;
			dec_forward_o <= dec_valid_i &&
				(dec_from_sec_i ? dec_up : dec_down);
			ab_rdata_o <= ab_rdata;
			ab_drop_wr_o <= ab_drop;
			ab_send_ur_o <= ab_ur;
			ab_tabort_o <= ab_ta;
			pri_serr_o <= serr_fwd;
			sec_perr_report_o <= perr_rep;
			poison_o <= pci_data_err_i;
		end
	end

	assign ev = {ab_pw_err, perr_rep, serr_fwd};

	// Sticky status; a new event wins over a write-one clear.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_q <= {`BFC_EV_W{1'b0}};
		end else begin
			if (reg_wr_i && reg_addr_i == `BFC_OFF_STAT) begin
				stat_q <= (stat_q & ~reg_wdata_i[`BFC_EV_W-1:0]) | ev;
			end else begin
				stat_q <= stat_q | ev;
			end
		end
	end

	assign irq_o = |(stat_q & mask_q);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`BFC_OFF_CTRL: begin
					reg_rdata_o <= {26'h0000000, ctrl_q};
				end
				`BFC_OFF_CAPID: begin
					reg_rdata_o <= {24'h000000, `BFC_CAPID_VAL};
				end
				`BFC_OFF_NEXT: begin
					reg_rdata_o <= {24'h000000, `BFC_NEXT_VAL};
				end
				`BFC_OFF_CMD: begin
					reg_rdata_o <= {23'h000000, cmd_q[`BFC_CMD_SERR], 6'h00,
						cmd_q[`BFC_CMD_MEM], cmd_q[`BFC_CMD_IO]};
				end
				`BFC_OFF_STAT: begin
					reg_rdata_o <= {29'h00000000, stat_q};
				end
				`BFC_OFF_MASK: begin
					reg_rdata_o <= {29'h00000000, mask_q};
				end
				default: begin
					reg_rdata_o <= 32'h00000000;
				end
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end
endmodule // bfc_top

// ==== tb/bfc_top_props.sv ====
// Checker for the bridge forwarding control ports.
module bfc_chk (
	input clk_i,
	input arst_n_i,
	input [7:0] reg_addr_i,
	input [31:0] reg_wdata_i,
	input reg_wr_i,
	input reg_rd_i,
	input [31:0] reg_rdata_o,
	input ab_mabort_i,
	input ab_is_read_i,
	input ab_posted_i,
	input ab_pcie_ur_i,
	input [31:0] ab_rdata_o,
	input ab_send_ur_o,
	input ab_tabort_o,
	input sec_perr_i,
	input sec_perr_report_o,
	input pci_data_err_i,
	input poison_o,
	input pri_serr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] ctl_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ctl_q <= 6'h00;
		else if (reg_wr_i && reg_addr_i == 8'h3e)
			ctl_q <= reg_wdata_i[5:0];
	end
	a_capid_fixed: assert property (reg_rd_i && reg_addr_i == 8'h50
		|=> reg_rdata_o == 32'h01) else $error("capid");
	a_next_fixed: assert property (reg_rd_i && reg_addr_i == 8'h51
		|=> reg_rdata_o == 32'h60) else $error("next pointer");
	a_abort_ones: assert property (!ctl_q[5] && ab_mabort_i
		&& ab_is_read_i |=> ab_rdata_o == 32'hffffffff) else $error("ones");
	a_abort_silent: assert property (!ctl_q[5]
		|=> !ab_send_ur_o && !ab_tabort_o) else $error("silent");
	a_ur_sent: assert property (ctl_q[5] && ab_mabort_i
		&& !ab_posted_i |=> ab_send_ur_o) else $error("ur");
	a_target_abort: assert property (ctl_q[5] && ab_pcie_ur_i
		|=> ab_tabort_o) else $error("tabort");
	a_poison_always: assert property (pci_data_err_i
		|=> poison_o) else $error("poison");
	a_parity_gate: assert property (sec_perr_report_o
		|-> $past(sec_perr_i && ctl_q[0])) else $error("parity");
	a_serr_gate: assert property (pri_serr_o
		|-> $past(ctl_q[1])) else $error("serr");
endmodule // bfc_chk
bind bfc_top bfc_chk u_chk (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .ab_mabort_i, .ab_is_read_i,
	.ab_posted_i, .ab_pcie_ur_i, .ab_rdata_o, .ab_send_ur_o, .ab_tabort_o,
	.sec_perr_i, .sec_perr_report_o, .pci_data_err_i, .poison_o, .pri_serr_o);

// ==== tb/bfc_far.sv ====
// Far-side model: PCI bus and PCI Express link error events.
module bfc_far (
	input logic [2:0] op_i,
	output logic mabort_o,
	output logic is_read_o,
	output logic posted_o,
	output logic ur_o,
	output logic serr_n_o,
	output logic perr_o,
	output logic derr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign mabort_o = op_i inside {3'h1, 3'h2, 3'h3};
	assign is_read_o = op_i == 3'h1;
	assign posted_o = op_i == 3'h2;
	assign ur_o = op_i == 3'h4;
	assign perr_o = op_i == 3'h5;
	assign derr_o = op_i == 3'h6;
	// The system-error line has a pull-up, so it idles high.
	assign serr_n_o = op_i != 3'h7;
endmodule // bfc_far

// ==== tb/tb.sv ====
// Self-checking bench for the bridge forwarding control block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, arst_n_i, reg_wr_i, reg_rd_i, irq_o, dec_valid_i, rd_q;
	logic dec_from_sec_i, dec_is_io_i, dec_is_mem_i, dec_in_window_i;
	logic dec_done_o, dec_forward_o, ab_mabort_i, ab_is_read_i, ab_posted_i;
	logic ab_pcie_ur_i, ab_drop_wr_o, ab_send_ur_o, ab_tabort_o, sec_serr_n_i;
	logic sec_perr_i, pci_data_err_i, pri_serr_o, sec_perr_report_o, poison_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, dec_addr_i, ab_rdata_i, ab_rdata_o;
	logic [2:0] op = 3'h0;
	logic [31:0] rq[$];
	logic dq[$];
	logic [31:0] rs = 32'h55;
	int bad_count = 0;
	int checked = 0;
	bfc_top uut (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .irq_o, .dec_valid_i, .dec_from_sec_i,
		.dec_addr_i, .dec_is_io_i, .dec_is_mem_i, .dec_in_window_i, .dec_done_o,
		.dec_forward_o, .ab_mabort_i, .ab_is_read_i, .ab_posted_i, .ab_rdata_i,
		.ab_pcie_ur_i, .ab_rdata_o, .ab_drop_wr_o, .ab_send_ur_o, .ab_tabort_o,
		.sec_serr_n_i, .sec_perr_i, .pci_data_err_i, .pri_serr_o,
		.sec_perr_report_o, .poison_o);
	bfc_far far (.op_i(op), .mabort_o(ab_mabort_i), .is_read_o(ab_is_read_i),
		.posted_o(ab_posted_i), .ur_o(ab_pcie_ur_i), .serr_n_o(sec_serr_n_i),
		.perr_o(sec_perr_i), .derr_o(pci_data_err_i));
	function automatic logic [31:0] nxt(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		rq.push_back(e);
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic dec(input logic s, io, w, input logic [31:0] a, logic e);
		{dec_from_sec_i, dec_is_io_i, dec_is_mem_i} <= {s, io, !io};
		dec_in_window_i <= w;
		dec_addr_i <= a;
		dec_valid_i <= 1'b1;
		dq.push_back(e);
		@(posedge clk_i);
		dec_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i)
		rd_q <= reg_rd_i;
	// Results are compared mid-cycle, once the edge's updates have landed.
	always @(negedge clk_i) begin
		if (rd_q)
			chk(reg_rdata_o, rq.pop_front());
		if (dec_done_o)
			chk(dec_forward_o, dq.pop_front());
	end
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		{arst_n_i, reg_wr_i, reg_rd_i, dec_valid_i} = 4'h0;
		{dec_from_sec_i, dec_is_io_i, dec_is_mem_i, dec_in_window_i} = 4'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		dec_addr_i = 32'h0;
		ab_rdata_i = 32'h0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		wr(8'h50, 32'hff);
		rd(8'h50, 32'h01);
		rd(8'h51, 32'h60);
		rd(8'h3e, 32'h0);
		wr(8'h04, 32'h103);
		wr(8'h3e, 32'h08);
		for (int i = 0; i < 8; i++) begin
			rs = nxt(rs);
			dec(0, 0, 0, 32'h000a0000 + {15'h0, rs[16:0]}, 1);
		end
		dec(1, 0, 1, 32'h000b0000, 0);
		dec(0, 1, 0, 32'h3bb, 1);
		dec(0, 1, 0, 32'hffc0, 1);
		dec(0, 1, 0, 32'h103df, 0);
		dec(1, 1, 0, 32'h3b0, 0);
		wr(8'h3e, 32'h18);
		dec(0, 1, 0, 32'hffc0, 0);
		dec(0, 1, 0, 32'h3df, 1);
		wr(8'h04, 32'h102);
		dec(0, 1, 1, 32'h3b0, 0);
		wr(8'h04, 32'h103);
		wr(8'h3e, 32'h04);
		dec(0, 1, 1, 32'h0500, 0);
		dec(0, 1, 1, 32'h0400, 1);
		dec(1, 1, 1, 32'h0500, 1);
		for (int c = 0; c < 2; c++) begin
			wr(8'h3e, c ? 32'h23 : 32'h0);
			for (int k = 1; k < 8; k++) begin
				rs = nxt(rs);
				ab_rdata_i <= rs;
				op <= k[2:0];
				repeat (4) @(posedge clk_i);
				chk(ab_rdata_o, (k == 1 && c == 0) ? 32'hffffffff : rs);
				chk(ab_drop_wr_o, (k == 2 || k == 3) && c == 0);
				chk(ab_send_ur_o, (k == 1 || k == 3) && c == 1);
				chk(ab_tabort_o, k == 4 && c == 1);
				chk(sec_perr_report_o, k == 5 && c == 1);
				chk(poison_o, k == 6);
				op <= 3'h0;
				repeat (8) @(posedge clk_i);
			end
			rd(8'h70, c ? 32'h7 : 32'h0);
		end
		chk(irq_o, 0);
		wr(8'h74, 32'h7);
		chk(irq_o, 1);
		wr(8'h70, 32'h7);
		chk(irq_o, 0);
		rd(8'h70, 32'h0);
		rd(8'h90, 32'h0);
		repeat (3) @(posedge clk_i);
		bad_count += rq.size() + dq.size();
		summarize();
	end
endmodule // tb
